/* rtl/rsc_pkg.sv */
// Shared constants and types of the reset source and state control block.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package rsc_pkg;

  // System clock rate and nominal low-speed oscillator rate
  localparam int CLK_HZ   = 50_000_000;
  localparam int LOW_SPEED_INTERNAL_OSC_HZ  = 32_000;
  // Cycles per low-speed tick, rounded down
  localparam int LOW_SPEED_INTERNAL_OSC_DIV = CLK_HZ / LOW_SPEED_INTERNAL_OSC_HZ;
  // Low-speed ticks a fault must persist; gives a 2 to 3 period delay
  localparam int QUAL_TICKS = 3;
  // System clock cycles that the core reset pulse lasts
  localparam int HOLD_CYC   = 4;
  // Watchdog time-out in low-speed ticks
  localparam int WDT_LIMIT  = 256;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_LVL_SEL = 8'h08;
  localparam logic [7:0] OFS_IO_DIR  = 8'h0C;
  localparam logic [7:0] OFS_IO_DATA = 8'h10;
  localparam logic [7:0] OFS_INT_EN  = 8'h14;
  localparam logic [7:0] OFS_TMR_ON  = 8'h18;
  localparam logic [7:0] OFS_WDT_CNT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h28;

  // Field positions
  localparam int CTRL_BADLVL_BIT = 0;
  localparam int CTRL_LOWVOLT_BIT = 1;
  localparam int ST_TO_BIT  = 0;
  localparam int ST_PDF_BIT = 1;

  // Reset values and valid level codes
  localparam logic [7:0] LVL_SEL_POR = 8'h55;
  localparam logic [7:0] LVL_CODE_B  = 8'h33;
  localparam logic [7:0] LVL_CODE_C  = 8'h99;
  localparam logic [7:0] LVL_CODE_D  = 8'hAA;
  localparam logic [7:0] IO_POR      = 8'hFF;
  localparam logic [7:0] INT_EN_POR  = 8'h00;
  localparam logic [1:0] TMR_ON_POR  = 2'h0;
  localparam logic [7:0] SP_TOP      = 8'h07;
  localparam logic [7:0] SP_ZERO     = 8'h00;

  // Operating modes reported by the core
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SLOW   = 2'b01,
    MODE_IDLE   = 2'b10,
    MODE_SLEEP  = 2'b11
  } rsc_mode_t;

  // Reset causes; irq status bit n is cause n+1
  typedef enum logic [2:0] {
    CAUSE_NONE    = 3'b000,
    CAUSE_POR     = 3'b001,
    CAUSE_LVR     = 3'b010,
    CAUSE_WDT_RUN = 3'b011,
    CAUSE_WDT_SLP = 3'b100,
    CAUSE_BADLVL  = 3'b101
  } rsc_cause_t;

  // Architectural state owned by this block
  typedef struct packed {
    logic [7:0] io_dir;
    logic [7:0] io_data;
    logic [7:0] int_en;
    logic [1:0] tmr_on;
  } rsc_arch_t;

  // True for the four defined voltage level codes
  function automatic logic lvl_valid(input logic [7:0] code);
    return (code == LVL_SEL_POR) || (code == LVL_CODE_B) ||
           (code == LVL_CODE_C) || (code == LVL_CODE_D);
  endfunction

endpackage

/* rtl/rsc_sync.sv */
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the inputs are slow levels, not pulses.
`timescale 1ns/100ps
`default_nettype none
module rsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  // First stage feeds only the second stage
  logic [WIDTH-1:0] meta_ff;

  // Two stages clear metastability before any logic looks
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_o  <= '0;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end
endmodule // rsc_sync
`default_nettype wire

/* rtl/rsc_qual.sv */
// Fault qualifier: a condition must hold over several low-speed ticks.
// Assumes tick_i is a one-cycle enable on the system clock.
`timescale 1ns/100ps
`default_nettype none
module rsc_qual #(
  parameter int TICKS = rsc_pkg::QUAL_TICKS
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic cond_i,
  output logic      fire_o
);
  logic [3:0] cnt_ff; // Ticks seen with the condition held

  // Count ticks while held; drop to zero the moment it goes away
  always_ff @(posedge clock_i) begin
    if (rst_i || !cond_i) begin
      cnt_ff <= 4'h0;
      fire_o <= 1'b0;
    end else if (tick_i && cnt_ff == 4'(TICKS - 1)) begin
      cnt_ff <= 4'h0;
      fire_o <= 1'b1; // Third tick: 2 to 3 periods after onset
    end else begin
      cnt_ff <= tick_i ? cnt_ff + 4'h1 : cnt_ff;
      fire_o <= 1'b0;
    end
  end
endmodule // rsc_qual
`default_nettype wire

/* rtl/rsc_top.sv */
// Reset source and state control: decides cause, flags and reset scope.
// Assumes an APB master on clock_i; lowvolt_i is an asynchronous pin.
// How it works
// - Normal watchdog reset equals low-voltage reset plus flag
// - Sleep watchdog reset clears only counter and stack
// - Power-on clears time-out and power-down flags
// - Low-voltage reset keeps both status flags
// - Normal watchdog reset sets time-out, keeps power-down
// - Sleep watchdog reset sets both status flags
// - Watchdog counter clears then counts at once
// - Power-on disables every interrupt source
// - Power-on switches every timer off
// - Full resets make all pins inputs, data ones
// - Power-on puts stack pointer at top
// - Full resets load defaults; sleep reset keeps state
// - Genuine low-voltage sets flag; only software or power-on clears
// - Undefined level code resets after 2-3 ticks
`timescale 1ns/100ps
`default_nettype none
module rsc_top #(
  parameter int LOW_SPEED_INTERNAL_OSC_DIV  = rsc_pkg::LOW_SPEED_INTERNAL_OSC_DIV,
  parameter int WDT_LIMIT = rsc_pkg::WDT_LIMIT
) (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // APB slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // Core side
  input  wire logic               lowvolt_i,
  input  wire logic [1:0]         mode_i,
  input  wire logic               halt_i,
  output logic                    core_rst_o,
  output logic                    pc_clear_o,
  output logic                    sp_load_o,
  output logic      [7:0]         sp_value_o,
  output rsc_pkg::rsc_arch_t      arch_o,
  output logic                    irq_o
);

  // Sequencer states
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HOLD = 2'b01
  } rsc_state_t;

  rsc_state_t          state_ff;      // Sequencer state
  logic [2:0]          hold_cnt_ff;   // Cycles left in reset pulse
  rsc_pkg::rsc_cause_t cause_ff;      // Last reset cause
  logic [1:0]          cause_mode_ff; // Mode at last reset
  logic                to_ff;         // Watchdog time-out flag
  logic                pdf_ff;        // Power-down flag
  logic                lowvolt_flag_ff;
  logic                badlvl_flag_ff;
  logic [7:0]          lvl_sel_ff;    // Voltage level select
  logic [15:0]         wdt_cnt_ff;    // Watchdog counter
  logic [10:0]         div_ff;        // Low-speed tick divider
  logic                tick_ff;       // Low-speed tick enable
  logic [4:0]          irq_st_ff;     // Sticky reset events
  logic [4:0]          irq_en_ff;     // Event enables
  logic [31:0]         nxt_prdata;
  logic                lowvolt_s;     // Synchronised pin
  logic                lvr_fire;
  logic                bad_fire;
  logic                wdt_fire;
  rsc_pkg::rsc_cause_t nxt_cause;
  logic                apply;         // One cycle: reset acted on
  logic                full_rst;      // Reset with default reload
  logic                wr_en;
  logic                rd_en;
  logic                mapped;
  logic                cond_lvr;

  // Low-speed oscillator as a one-cycle enable
  always_ff @(posedge clock_i) begin
    if (rst_i || div_ff == 11'(LOW_SPEED_INTERNAL_OSC_DIV - 1)) begin
      div_ff <= 11'h000;
    end else begin
      div_ff <= div_ff + 11'h001;
    end
  end

  // Tick comes one cycle after the wrap
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == 11'(LOW_SPEED_INTERNAL_OSC_DIV - 1));
    end
  end

  // Pin passes two flops first
  rsc_sync #(.WIDTH(1)) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (lowvolt_i),
    .sync_o  (lowvolt_s)
  );

  // Monitor is off in idle and sleep, and only with a valid level
  assign cond_lvr = lowvolt_s && !mode_i[1] && rsc_pkg::lvl_valid(lvl_sel_ff);

  // Genuine low voltage qualified by low-speed ticks
  rsc_qual u_lvr_qual (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tick_i  (tick_ff),
    .cond_i  (cond_lvr),
    .fire_o  (lvr_fire)
  );

  // Undefined level code, same 2 to 3 tick delay
  rsc_qual u_bad_qual (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tick_i  (tick_ff),
    .cond_i  (!rsc_pkg::lvl_valid(lvl_sel_ff)),
    .fire_o  (bad_fire)
  );

  assign wdt_fire = tick_ff && (wdt_cnt_ff == 16'(WDT_LIMIT - 1));

  // Cause priority: bad code, then low voltage, then watchdog
  always_comb begin
    nxt_cause = rsc_pkg::CAUSE_NONE;
    if (bad_fire) begin
      nxt_cause = rsc_pkg::CAUSE_BADLVL;
    end else if (lvr_fire) begin
      nxt_cause = rsc_pkg::CAUSE_LVR;
    end else if (wdt_fire) begin
      // Mode splits the watchdog into two kinds
      nxt_cause = mode_i[1] ? rsc_pkg::CAUSE_WDT_SLP : rsc_pkg::CAUSE_WDT_RUN;
    end
  end

  // Events during the reset pulse are dropped; faults persist anyway
  assign apply    = (state_ff == ST_RUN) && (nxt_cause != rsc_pkg::CAUSE_NONE);
  assign full_rst = apply && (nxt_cause != rsc_pkg::CAUSE_WDT_SLP);

  // Sequencer: act once, then hold core in reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff    <= ST_HOLD;
      hold_cnt_ff <= 3'(rsc_pkg::HOLD_CYC - 1);
    end else begin
      unique case (state_ff)
        ST_RUN: begin
          if (apply) begin
            state_ff    <= ST_HOLD;
            hold_cnt_ff <= 3'(rsc_pkg::HOLD_CYC - 1);
          end
        end
        ST_HOLD: begin
          if (hold_cnt_ff == 3'h0) begin
            state_ff <= ST_RUN;
          end else begin
            hold_cnt_ff <= hold_cnt_ff - 3'h1;
          end
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end

  // Core reset pulse and its companions
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      core_rst_o <= 1'b1;
      pc_clear_o <= 1'b1;
      sp_load_o  <= 1'b1;
      sp_value_o <= rsc_pkg::SP_TOP;
    end else begin
      core_rst_o <= apply || (state_ff == ST_HOLD && hold_cnt_ff != 3'h0);
      pc_clear_o <= apply;
      sp_load_o  <= apply;
      if (apply) begin
        // Sleep reset zeroes the stack; others start it empty
        sp_value_o <= full_rst ? rsc_pkg::SP_TOP : rsc_pkg::SP_ZERO;
      end
    end
  end

  // Record cause and mode of each reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cause_ff      <= rsc_pkg::CAUSE_POR;
      cause_mode_ff <= rsc_pkg::MODE_NORMAL;
    end else if (apply) begin
      cause_ff      <= nxt_cause;
      cause_mode_ff <= mode_i;
    end
  end

  // Status flags; a low-voltage reset touches neither
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      to_ff  <= 1'b0;
      pdf_ff <= 1'b0;
    end else if (apply && nxt_cause == rsc_pkg::CAUSE_WDT_RUN) begin
      to_ff <= 1'b1;
    end else if (apply && nxt_cause == rsc_pkg::CAUSE_WDT_SLP) begin
      to_ff  <= 1'b1;
      pdf_ff <= 1'b1;
    end else if (halt_i && state_ff == ST_RUN && !apply) begin
      pdf_ff <= 1'b1; // Core entering power-down
    end
  end

  assign wr_en  = psel_i && penable_i && pwrite_i;
  assign rd_en  = psel_i && !penable_i && !pwrite_i;

  // Sticky reset-cause flags; set beats a same-cycle software write
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lowvolt_flag_ff <= 1'b0;
      badlvl_flag_ff  <= 1'b0;
    end else begin
      if (apply && nxt_cause == rsc_pkg::CAUSE_LVR) begin
        lowvolt_flag_ff <= 1'b1;
      end else if (wr_en && paddr_i == rsc_pkg::OFS_CTRL) begin
        lowvolt_flag_ff <= pwdata_i[rsc_pkg::CTRL_LOWVOLT_BIT];
      end
      if (bad_fire) begin
        badlvl_flag_ff <= 1'b1;
      end else if (wr_en && paddr_i == rsc_pkg::OFS_CTRL) begin
        badlvl_flag_ff <= pwdata_i[rsc_pkg::CTRL_BADLVL_BIT];
      end
    end
  end

  // Level select: full resets reload the power-on code
  always_ff @(posedge clock_i) begin
    if (rst_i || full_rst) begin
      lvl_sel_ff <= rsc_pkg::LVL_SEL_POR;
    end else if (wr_en && paddr_i == rsc_pkg::OFS_LVL_SEL) begin
      lvl_sel_ff <= pwdata_i[7:0];
    end
  end

  // Architectural state; sleep watchdog reset leaves it alone
  always_ff @(posedge clock_i) begin
    if (rst_i || full_rst) begin
      arch_o.io_dir  <= rsc_pkg::IO_POR;
      arch_o.io_data <= rsc_pkg::IO_POR;
      arch_o.int_en  <= rsc_pkg::INT_EN_POR;
      arch_o.tmr_on  <= rsc_pkg::TMR_ON_POR;
    end else if (wr_en && !apply) begin
      // Every field has a defined value; nothing here is left unknown
      unique case (paddr_i)
        rsc_pkg::OFS_IO_DIR:  arch_o.io_dir  <= pwdata_i[7:0];
        rsc_pkg::OFS_IO_DATA: arch_o.io_data <= pwdata_i[7:0];
        rsc_pkg::OFS_INT_EN:  arch_o.int_en  <= pwdata_i[7:0];
        rsc_pkg::OFS_TMR_ON:  arch_o.tmr_on  <= pwdata_i[1:0];
        default: ;
      endcase
    end
  end

  // Watchdog counter: cleared by any reset, runs with no enable
  always_ff @(posedge clock_i) begin
    if (rst_i || apply) begin
      wdt_cnt_ff <= 16'h0000;
    end else if (wr_en && paddr_i == rsc_pkg::OFS_WDT_CNT) begin
      wdt_cnt_ff <= 16'h0000; // Software kick
    end else if (tick_ff) begin
      wdt_cnt_ff <= wdt_cnt_ff + 16'h0001;
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_st_ff <= 5'h00;
      irq_en_ff <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (apply && nxt_cause == rsc_pkg::rsc_cause_t'(3'(i + 1))) begin
          irq_st_ff[i] <= 1'b1;
        end else if (wr_en && paddr_i == rsc_pkg::OFS_IRQ_CLR && pwdata_i[i]) begin
          irq_st_ff[i] <= 1'b0;
        end
      end
      if (wr_en && paddr_i == rsc_pkg::OFS_IRQ_EN) begin
        irq_en_ff <= pwdata_i[4:0];
      end
    end
  end

  assign irq_o = |(irq_st_ff & irq_en_ff);

  // Read mux, sampled in the setup cycle
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    mapped     = 1'b1;
    unique case (paddr_i)
      rsc_pkg::OFS_CTRL:    nxt_prdata[1:0] = {lowvolt_flag_ff, badlvl_flag_ff};
      rsc_pkg::OFS_STATUS:  nxt_prdata[7:0] = {1'b0, cause_mode_ff, cause_ff, pdf_ff, to_ff};
      rsc_pkg::OFS_LVL_SEL: nxt_prdata[7:0] = lvl_sel_ff;
      rsc_pkg::OFS_IO_DIR:  nxt_prdata[7:0] = arch_o.io_dir;
      rsc_pkg::OFS_IO_DATA: nxt_prdata[7:0] = arch_o.io_data;
      rsc_pkg::OFS_INT_EN:  nxt_prdata[7:0] = arch_o.int_en;
      rsc_pkg::OFS_TMR_ON:  nxt_prdata[1:0] = arch_o.tmr_on;
      rsc_pkg::OFS_WDT_CNT: nxt_prdata[15:0] = wdt_cnt_ff;
      rsc_pkg::OFS_IRQ_ST:  nxt_prdata[4:0] = irq_st_ff;
      rsc_pkg::OFS_IRQ_CLR: nxt_prdata = 32'h0000_0000; // Write-only
      rsc_pkg::OFS_IRQ_EN:  nxt_prdata[4:0] = irq_en_ff;
      default:              mapped = 1'b0;
    endcase
  end

  // Read data held from a flop through the access phase
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_o <= nxt_prdata;
    end
  end

  // Zero-wait slave; error on unmapped address
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // Cycles the watchdog counter has sat at zero since its last clear.
  // A tick arrives within one divider period, so a long run means a stall;
  // counting here avoids a delay range as long as the divider period.
  logic [11:0] wdt_zero_run_ff;
  always_ff @(posedge clock_i) begin
    if (rst_i || apply || wdt_cnt_ff != 16'h0000) begin
      wdt_zero_run_ff <= 12'h000;
    end else if (wr_en && paddr_i == rsc_pkg::OFS_WDT_CNT) begin
      wdt_zero_run_ff <= 12'h000; // Software kick restarts the wait
    end else if (wdt_zero_run_ff != 12'hFFF) begin
      wdt_zero_run_ff <= wdt_zero_run_ff + 12'h001; // Saturates
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_wdt_run;
    apply && nxt_cause == rsc_pkg::CAUSE_WDT_RUN;
  endsequence
  sequence s_wdt_slp;
    apply && nxt_cause == rsc_pkg::CAUSE_WDT_SLP;
  endsequence

  a_por_flags_clear: assert property (disable iff (1'b0)
    rst_i ##1 !rst_i |-> !to_ff && !pdf_ff) else $error("flags not cleared by power-on");
  a_wdt_run_flags: assert property (
    s_wdt_run |=> to_ff && pdf_ff == $past(pdf_ff)) else $error("normal watchdog flags wrong");
  a_wdt_slp_flags: assert property (
    s_wdt_slp |=> to_ff && pdf_ff) else $error("sleep watchdog flags wrong");
  a_lvr_flags_kept: assert property (
    apply && nxt_cause == rsc_pkg::CAUSE_LVR |=> $stable(to_ff) && $stable(pdf_ff)
      && lowvolt_flag_ff) else $error("low-voltage reset changed flags");
  a_bad_code_reset: assert property (
    bad_fire |=> badlvl_flag_ff && lvl_sel_ff == rsc_pkg::LVL_SEL_POR && core_rst_o)
    else $error("bad level code not handled");
  a_full_defaults: assert property (
    s_wdt_run |=> arch_o.io_dir == 8'hFF && arch_o.io_data == 8'hFF
      && arch_o.int_en == 8'h00 && arch_o.tmr_on == 2'h0) else $error("defaults not loaded");
  a_slp_keeps_state: assert property (
    s_wdt_slp |=> $stable(arch_o) && sp_value_o == 8'h00 && pc_clear_o)
    else $error("sleep watchdog reset disturbed state");
  a_wdt_restarts: assert property (
    apply |=> wdt_cnt_ff == 16'h0000) else $error("watchdog not cleared by reset");
  a_wdt_runs_on: assert property (
    wdt_zero_run_ff <= 12'(LOW_SPEED_INTERNAL_OSC_DIV + 1)) else $error("watchdog did not restart");
  a_rst_pulse_len: assert property (
    apply |=> core_rst_o [*4] ##1 !core_rst_o) else $error("core reset pulse length wrong");

endmodule // rsc_top
`default_nettype wire

/* bench/reset_source_state_control_bench.sv */
// Self-checking bench for the reset source and state control block.
// Assumes rsc_pkg and rsc_top compiled first; drives APB and core pins itself.
`timescale 1ns/100ps
`default_nettype none
module reset_source_state_control_bench;
  // Design inputs
  logic        clock_i, rst_i, psel_i, penable_i, pwrite_i, lowvolt_i, halt_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [1:0]  mode_i;
  // Design outputs
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, core_rst_o, pc_clear_o, sp_load_o, irq_o;
  logic [7:0]  sp_value_o;
  rsc_pkg::rsc_arch_t arch_o;
  // Bench state
  int          bad_count, n_compared;
  logic [31:0] rd;                       // Last read data
  logic        er;                       // Last slave error
  logic [31:0] c1;                       // Earlier watchdog count
  // Defaults and a recognisable user pattern for the owned state
  localparam logic [25:0] ARCH_DEF = {8'hFF, 8'hFF, 8'h00, 2'h0};
  localparam logic [25:0] ARCH_USR = {8'h0F, 8'h3C, 8'hA5, 2'h3};

  // Small counts keep the watchdog window at 128 cycles
  rsc_top #(.LOW_SPEED_INTERNAL_OSC_DIV(4), .WDT_LIMIT(32)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .lowvolt_i(lowvolt_i), .mode_i(mode_i), .halt_i(halt_i),
    .core_rst_o(core_rst_o), .pc_clear_o(pc_clear_o), .sp_load_o(sp_load_o),
    .sp_value_o(sp_value_o), .arch_o(arch_o), .irq_o(irq_o));

  // 50 MHz system clock
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // Verdict and end of run, the only exit
  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Mismatch report
  task automatic fail(input string m);
    bad_count++;
    $display("ERROR at %0t: %s", $time, m);
  endtask

  // Word compare, four-state exact
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) fail($sformatf("%s got %h want %h", m, g, e));
  endtask

  // Single-bit compare
  task automatic cmp_bit(input logic g, input logic e, input string m);
    n_compared++;
    if (g !== e) fail($sformatf("%s got %b want %b", m, g, e));
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 50) begin
      fail("pready never came");
      summarize();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask

  // Load the user pattern into the owned state registers
  task automatic set_arch;
    apb(1'b1, rsc_pkg::OFS_IO_DIR, 32'h0000000F);
    apb(1'b1, rsc_pkg::OFS_IO_DATA, 32'h0000003C);
    apb(1'b1, rsc_pkg::OFS_INT_EN, 32'h000000A5);
    apb(1'b1, rsc_pkg::OFS_TMR_ON, 32'h00000003);
    // Last write lands at this edge; look only once it has settled
    @(negedge clock_i);
  endtask

  // Wait for a core reset; checks its pulses and its 4-cycle length
  task automatic expect_rst(input logic [7:0] sp);
    int i;
    int n;
    i = 0;
    @(posedge clock_i);
    while (core_rst_o !== 1'b1 && i < 3000) begin
      @(posedge clock_i);
      i++;
    end
    if (i == 3000) begin
      fail("no core reset");
      summarize();
    end
    cmp_bit(pc_clear_o, 1'b1, "pc clear");
    cmp_bit(sp_load_o, 1'b1, "sp load");
    cmp_word({24'h0, sp_value_o}, {24'h0, sp}, "sp value");
    n = 0;
    while (core_rst_o === 1'b1 && n < 20) begin
      n++;
      @(posedge clock_i);
    end
    cmp_word(n, 32'h4, "reset length");
  endtask

  // Status flags and cause in the low five bits
  task automatic chk_status(input logic [4:0] e, input string m);
    apb(1'b0, rsc_pkg::OFS_STATUS, 32'h0);
    cmp_word({27'h0, rd[4:0]}, {27'h0, e}, m);
  endtask

  // Main sequence
  initial begin
    bad_count = 0; n_compared = 0;
    rst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 8'h00; pwdata_i = 32'h0; lowvolt_i = 1'b0; halt_i = 1'b0;
    mode_i = rsc_pkg::MODE_NORMAL;
    repeat (12) @(posedge clock_i);
    cmp_word({24'h0, sp_value_o}, 32'h07, "stack top");
    rst_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    // Power-on state
    cmp_word({6'h0, arch_o}, {6'h0, ARCH_DEF}, "por state");
    chk_status(5'h04, "por flags");
    apb(1'b0, rsc_pkg::OFS_LVL_SEL, 32'h0);
    cmp_word(rd, 32'h55, "level select por");
    apb(1'b0, rsc_pkg::OFS_WDT_CNT, 32'h0);
    c1 = rd;
    repeat (12) @(posedge clock_i);
    apb(1'b0, rsc_pkg::OFS_WDT_CNT, 32'h0);
    cmp_bit(rd > c1, 1'b1, "watchdog counting");
    $display("Test power-on done");
    // Watchdog in normal mode: full defaults, time-out set, power-down kept at 0
    set_arch();
    cmp_word({6'h0, arch_o}, {6'h0, ARCH_USR}, "user state");
    expect_rst(8'h07);
    cmp_word({6'h0, arch_o}, {6'h0, ARCH_DEF}, "wdt normal state");
    chk_status(5'h0D, "wdt normal flags");
    $display("Test watchdog normal done");
    // Watchdog in sleep: state kept, both flags high
    set_arch();
    @(posedge clock_i);
    halt_i <= 1'b1;
    @(posedge clock_i);
    halt_i <= 1'b0;
    mode_i <= rsc_pkg::MODE_SLEEP;
    expect_rst(8'h00);
    cmp_word({6'h0, arch_o}, {6'h0, ARCH_USR}, "sleep state kept");
    mode_i <= rsc_pkg::MODE_NORMAL;
    chk_status(5'h13, "wdt sleep flags");
    $display("Test watchdog sleep done");
    // Low-voltage reset with both flags already set: they must survive
    apb(1'b1, rsc_pkg::OFS_WDT_CNT, 32'h0);
    lowvolt_i <= 1'b1;
    expect_rst(8'h07);
    lowvolt_i <= 1'b0;
    // A repeated low-voltage reset may still follow; let it settle
    repeat (40) @(posedge clock_i);
    cmp_word({6'h0, arch_o}, {6'h0, ARCH_DEF}, "lvr state");
    chk_status(5'h0B, "lvr flags");
    apb(1'b0, rsc_pkg::OFS_CTRL, 32'h0);
    cmp_bit(rd[rsc_pkg::CTRL_LOWVOLT_BIT], 1'b1, "lowvolt flag");
    apb(1'b1, rsc_pkg::OFS_CTRL, 32'h0);
    apb(1'b0, rsc_pkg::OFS_CTRL, 32'h0);
    cmp_bit(rd[rsc_pkg::CTRL_LOWVOLT_BIT], 1'b0, "lowvolt flag cleared");
    $display("Test low voltage done");
    // Undefined level code: reset, flag set, register back to its default
    apb(1'b1, rsc_pkg::OFS_WDT_CNT, 32'h0);
    apb(1'b1, rsc_pkg::OFS_LVL_SEL, 32'h00000012);
    expect_rst(8'h07);
    apb(1'b0, rsc_pkg::OFS_LVL_SEL, 32'h0);
    cmp_word(rd, 32'h55, "level select reload");
    apb(1'b0, rsc_pkg::OFS_CTRL, 32'h0);
    cmp_bit(rd[rsc_pkg::CTRL_BADLVL_BIT], 1'b1, "bad code flag");
    $display("Test bad code done");
    // Interrupt from the normal watchdog cause: mask, enable, clear
    apb(1'b1, rsc_pkg::OFS_IRQ_EN, 32'h0);
    @(negedge clock_i);
    cmp_bit(irq_o, 1'b0, "irq masked");
    apb(1'b1, rsc_pkg::OFS_IRQ_EN, 32'h04);
    @(negedge clock_i);
    cmp_bit(irq_o, 1'b1, "irq enabled");
    apb(1'b1, rsc_pkg::OFS_IRQ_CLR, 32'h1F);
    @(negedge clock_i);
    cmp_bit(irq_o, 1'b0, "irq cleared");
    apb(1'b0, rsc_pkg::OFS_IRQ_ST, 32'h0);
    cmp_word(rd, 32'h0, "irq status");
    // Unmapped address refused
    apb(1'b0, 8'h40, 32'h0);
    cmp_bit(er, 1'b1, "slave error");
    cmp_word(rd, 32'h0, "unmapped data");
    $display("Test interrupt and bus done");
    // Second power-on clears both flags again
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    chk_status(5'h04, "second por flags");
    cmp_word({6'h0, arch_o}, {6'h0, ARCH_DEF}, "second por state");
    $display("Test second power-on done");
    summarize();
  end
endmodule // reset_source_state_control_bench
`default_nettype wire
